// >>> i2c_enable_spike_regs.svh
`ifndef I2C_ENABLE_SPIKE_REGS_SVH
`define I2C_ENABLE_SPIKE_REGS_SVH

// Byte addresses on the register port
`define ENABLE_STATE_READBACK_OFS 32'h5000_139c
`define GLITCH_FILTER_WIDTH_OFS 32'h5000_13a0
`define IRQ_STATUS_OFS 32'h5000_13a4
`define IRQ_MASK_OFS 32'h5000_13a8

// Fields of the readback, status and mask registers
`define ACTIVE_BIT 0
`define DISABLE_ABORT_BIT 1
`define RX_LOSS_BIT 2

// Reset values
`define ENABLE_STATE_READBACK_RST 16'h0000
`define GLITCH_FILTER_WIDTH_RST 8'h01
`define IRQ_STATUS_RST 3'h0
`define IRQ_MASK_RST 3'h0

// Spike length limits and bit counts
`define SPIKE_LEN_MIN 8'h01
`define BITS_PER_BYTE 4'h8

`endif

// >>> i2c_enable_spike_pkg.sv
package i2c_enable_spike_pkg;

   typedef enum logic [5:0] {
      sIdle = 6'h01,
      sAddr = 6'h02,
      sAddrAck = 6'h04,
      sData = 6'h08,
      sDataAck = 6'h10,
      sSkip = 6'h20
   } slave_state_e;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic level;
      logic [7:0] cnt;
   } filter_s;

   typedef struct packed {
      slave_state_e state;
      logic enableQ;
      logic pending;
      logic active;
      logic abortFlag;
      logic lossFlag;
      logic [3:0] bitCnt;
      logic [7:0] shiftReg;
      logic rw;
      logic matched;
      logic [7:0] spkLen;
      logic [2:0] irqStatus;
      logic [2:0] irqMask;
      logic irq;
      logic [31:0] rdata;
      logic sdaOe;
      logic sdaLow;
      logic sclPrev;
      logic sdaPrev;
   } ctrl_s;

endpackage : i2c_enable_spike_pkg

// >>> spike_suppressor.sv
`timescale 1ns/1ps

module spike_suppressor
   import i2c_enable_spike_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic lineIn,
   input wire logic [7:0] spkLen,
   output logic lineOut
);

   filter_s q;
   filter_s d;

   always_comb begin
      d = q;
      d.sync1 = lineIn;
      d.sync2 = q.sync1;
      // New level must hold longer than spkLen cycles
      if (q.sync2 == q.level) begin
         d.cnt = 8'h00;
      end else if (q.cnt >= spkLen) begin
         d.level = q.sync2;
         d.cnt = 8'h00;
      end else begin
         d.cnt = q.cnt + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= '0;
         // Idle bus is high
         q.sync1 <= 1'b1;
         q.sync2 <= 1'b1;
         q.level <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign lineOut = q.level;

   a_level_after_hold: assert property (@(posedge clk) disable iff (!nrst)
      $changed(q.level) |-> $past(q.cnt) == $past(spkLen) && q.level == $past(q.sync2))
      else $error("filtered level changed before the hold count was reached");

endmodule : spike_suppressor

// >>> i2c_enable_spike_top.sv
// Overview of operation
// - Disabling during the data phase of an addressed slave-receive sets the receive-loss flag.
// - The receive-loss flag is also set when a STOP ends that transfer before the forced NACK.
// - Disabling while an address byte or slave-receive data arrives sets the disable-abort flag.
// - A set disable-abort flag means the disable fell in an address byte or in slave-receive data, whether the address matched or not.
// - The disable-abort flag is also set when a STOP comes before the forced NACK.
// - Disabling while the bus is idle or carries other traffic past its address byte leaves disable-abort at zero.
// - The active bit always equals the internal enable output of the controller.
// - Pulses on SCL and SDA no longer than the spike length, in clock cycles, are dropped.
// - Writes to the spike length are taken only while the enable control is zero.
// - The spike length never holds less than one; a smaller write stores one.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps

`include "i2c_enable_spike_regs.svh"

module i2c_enable_spike_top
   import i2c_enable_spike_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic controllerEnable,
   input wire logic [6:0] ownSlaveAddress,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic irq,
   output logic controllerActive,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe
);

   ////////////////////////////////////////////////////////////////////////////////
   // Spike suppression on both bus lines

   logic [1:0] rawLines;
   logic [1:0] filtLines;
   logic sclF;
   logic sdaF;

   ctrl_s q;
   ctrl_s d;

   assign rawLines = {sdaIn, sclIn};

   generate
      for (genvar i = 0; i < 2; i++) begin : gLine
         spike_suppressor uFilter (
            .clk(clk),
            .nrst(nrst),
            .lineIn(rawLines[i]),
            .spkLen(q.spkLen),
            .lineOut(filtLines[i])
         );
      end
   endgenerate

   assign sclF = filtLines[0];
   assign sdaF = filtLines[1];

   ////////////////////////////////////////////////////////////////////////////////
   // Bus condition detection

   logic startCond;
   logic stopCond;
   logic sclRise;
   logic sclFall;
   logic disableEv;
   logic enableEv;
   logic addrPhase;
   logic rxData;

   assign startCond = sclF && q.sclPrev && q.sdaPrev && !sdaF;
   assign stopCond = sclF && q.sclPrev && !q.sdaPrev && sdaF;
   assign sclRise = sclF && !q.sclPrev;
   assign sclFall = !sclF && q.sclPrev;
   assign disableEv = q.enableQ && !controllerEnable;
   assign enableEv = !q.enableQ && controllerEnable;
   // Address byte on the wire, matched or not
   assign addrPhase = (q.state == sAddr);
   // Data phase is only reached by an addressed write
   assign rxData = (q.state == sData) || (q.state == sDataAck);

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   logic [2:0] clrMask;
   logic [2:0] events;

   always_comb begin
      d = q;
      clrMask = 3'h0;
      events = 3'h0;
      d.sclPrev = sclF;
      d.sdaPrev = sdaF;
      d.enableQ = controllerEnable;
      d.rdata = 32'h0000_0000;

      // Slave byte tracker; ACK only while enabled, so disabling forces a NACK
      if (startCond) begin
         d.state = sAddr;
         d.bitCnt = 4'h0;
         d.sdaOe = 1'b0;
      end else if (stopCond) begin
         d.state = sIdle;
         d.sdaOe = 1'b0;
      end else begin
         case (q.state)
            sIdle: begin
               d.state = sIdle;
            end
            sAddr: begin
               if (sclRise && q.bitCnt < `BITS_PER_BYTE) begin
                  d.shiftReg = {q.shiftReg[6:0], sdaF};
                  d.bitCnt = q.bitCnt + 4'h1;
               end else if (sclFall && q.bitCnt == `BITS_PER_BYTE) begin
                  d.state = sAddrAck;
                  d.matched = (q.shiftReg[7:1] == ownSlaveAddress);
                  d.rw = q.shiftReg[0];
                  d.sdaOe = (q.shiftReg[7:1] == ownSlaveAddress) && controllerEnable;
               end
            end
            sAddrAck: begin
               if (sclFall) begin
                  d.sdaOe = 1'b0;
                  d.bitCnt = 4'h0;
                  // Slave transmit data is served elsewhere
                  d.state = (q.matched && !q.rw && controllerEnable) ? sData : sSkip;
               end
            end
            sData: begin
               if (sclRise && q.bitCnt < `BITS_PER_BYTE) begin
                  d.shiftReg = {q.shiftReg[6:0], sdaF};
                  d.bitCnt = q.bitCnt + 4'h1;
               end else if (sclFall && q.bitCnt == `BITS_PER_BYTE) begin
                  d.state = sDataAck;
                  d.sdaOe = controllerEnable;
               end
            end
            sDataAck: begin
               if (sclFall) begin
                  d.sdaOe = 1'b0;
                  d.bitCnt = 4'h0;
                  d.state = controllerEnable ? sData : sSkip;
               end
            end
            sSkip: begin
               d.state = sSkip;
            end
            default: begin
               d.state = sIdle;
               d.sdaOe = 1'b0;
            end
         endcase
      end

      // Aborted transfer ends at its NACK slot or at START/STOP
      if (q.pending && (startCond || stopCond || d.state != q.state)) begin
         d.pending = 1'b0;
      end

      // Flags belong to the last disable; a fresh enable clears them
      if (enableEv) begin
         d.abortFlag = 1'b0;
         d.lossFlag = 1'b0;
         d.pending = 1'b0;
      end else if (disableEv) begin
         if (addrPhase || rxData) begin
            // Set at the disable, so a STOP before the NACK keeps them
            d.abortFlag = 1'b1;
            d.pending = !(startCond || stopCond || d.state != q.state);
         end
         if (rxData) begin
            d.lossFlag = 1'b1;
         end
      end

      d.active = controllerEnable || d.pending;

      // Register writes
      if (wr) begin
         case (addr)
            `GLITCH_FILTER_WIDTH_OFS: begin
               if (!controllerEnable) begin
                  d.spkLen = (wdata[7:0] < `SPIKE_LEN_MIN) ? `SPIKE_LEN_MIN : wdata[7:0];
               end
            end
            `IRQ_STATUS_OFS: begin
               clrMask = wdata[2:0];
            end
            `IRQ_MASK_OFS: begin
               d.irqMask = wdata[2:0];
            end
            default: begin
               clrMask = 3'h0;
            end
         endcase
      end

      // Sticky events; a set in the clearing cycle wins
      events[`ACTIVE_BIT] = q.active && !d.active;
      events[`DISABLE_ABORT_BIT] = d.abortFlag && !q.abortFlag;
      events[`RX_LOSS_BIT] = d.lossFlag && !q.lossFlag;
      d.irqStatus = (q.irqStatus & ~clrMask) | events;
      d.irq = |(d.irqStatus & d.irqMask);

      // Register reads, data valid in the next cycle only
      if (rd) begin
         case (addr)
            `ENABLE_STATE_READBACK_OFS: begin
               d.rdata = {29'h0000_0000, q.lossFlag, q.abortFlag, q.active};
            end
            `GLITCH_FILTER_WIDTH_OFS: begin
               d.rdata = {24'h00_0000, q.spkLen};
            end
            `IRQ_STATUS_OFS: begin
               d.rdata = {29'h0000_0000, q.irqStatus};
            end
            `IRQ_MASK_OFS: begin
               d.rdata = {29'h0000_0000, q.irqMask};
            end
            default: begin
               d.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= '0;
         q.state <= sIdle;
         q.spkLen <= `GLITCH_FILTER_WIDTH_RST;
         q.irqStatus <= `IRQ_STATUS_RST;
         q.irqMask <= `IRQ_MASK_RST;
         q.sclPrev <= 1'b1;
         q.sdaPrev <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign rdata = q.rdata;
   assign irq = q.irq;
   assign controllerActive = q.active;
   assign sdaOut = q.sdaLow;
   assign sdaOe = q.sdaOe;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk);
   endclocking

   default disable iff (!nrst);

   sequence disableInAddr;
      q.enableQ && !controllerEnable && q.state == sAddr;
   endsequence

   sequence disableInRxData;
      q.enableQ && !controllerEnable && (q.state == sData || q.state == sDataAck);
   endsequence

   sequence disableQuiet;
      q.enableQ && !controllerEnable && (q.state == sIdle || q.state == sSkip);
   endsequence

   sequence lockedSpikeWrite;
      wr && addr == `GLITCH_FILTER_WIDTH_OFS && controllerEnable;
   endsequence

   a_rx_loss_set: assert property (disableInRxData |=> q.lossFlag && q.abortFlag)
      else $error("receive loss not flagged on disable in data phase");

   a_addr_abort_set: assert property (disableInAddr |=> q.abortFlag && !q.lossFlag)
      else $error("disable abort not flagged on disable in address byte");

   a_quiet_disable: assert property (disableQuiet |=> !q.abortFlag && !controllerActive)
      else $error("quiet disable flagged or left active");

   a_stop_ends_abort: assert property (q.pending && stopCond |=> !controllerActive && q.abortFlag)
      else $error("stop during abort did not end activity with flag kept");

   a_flags_kept_stop: assert property (q.lossFlag && !controllerEnable && stopCond |=> q.lossFlag)
      else $error("receive loss cleared by stop");

   a_active_enable: assert property (controllerEnable |=> controllerActive)
      else $error("active not raised after enable");

   a_readback_active: assert property (rd && addr == `ENABLE_STATE_READBACK_OFS |=> rdata[`ACTIVE_BIT] == $past(controllerActive))
      else $error("readback active bit differs from enable output");

   a_forced_nack: assert property (!controllerEnable && sclFall && q.bitCnt == `BITS_PER_BYTE |=> !sdaOe)
      else $error("ack driven while disabled");

   a_spike_locked: assert property (lockedSpikeWrite |=> $stable(q.spkLen))
      else $error("spike length changed while enabled");

   a_spike_min: assert property (wr && addr == `GLITCH_FILTER_WIDTH_OFS && !controllerEnable && wdata[7:0] == 8'h00 |=> q.spkLen == 8'h01 ##1 q.spkLen != 8'h00)
      else $error("spike length stored below one");

   a_irq_level: assert property ((q.irqStatus & q.irqMask) != 3'h0 |-> irq)
      else $error("interrupt low with unmasked status set");

endmodule : i2c_enable_spike_top

// >>> remote_master.sv
`timescale 1ns/1ps

module remote_master (
   output logic scl,
   output logic sdaDrv,
   input wire logic sdaIn
);
   int spkNs = 0;

   // Released SDA reads high through the pull-up; SCL stands high between frames
   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end

   task automatic start();
      sdaDrv = 1'b0;
      #50;
      scl = 1'b0;
      #50;
   endtask : start

   // Optional spikes of at most one clock sample: on SCL 5 ns after the data change, mid low phase,
   // on SDA in mid high phase; two clean samples precede each, so real edges survive
   task automatic bitOut(input logic b);
      sdaDrv = b;
      if (spkNs > 0) begin
         #5;
         scl = 1'b1;
         #(spkNs);
         scl = 1'b0;
         #(45 - spkNs);
      end else begin
         #50;
      end
      scl = 1'b1;
      #55;
      if (spkNs > 0) begin
         sdaDrv = ~b;
         #(spkNs);
         sdaDrv = b;
      end
      #(45 - spkNs);
      scl = 1'b0;
      #50;
   endtask : bitOut

   // Slave answers some cycles after the filtered SCL fall: both low phases stretched,
   // so its ACK lands before SCL rises and its release before the next bit
   task automatic getAck(output logic a);
      sdaDrv = 1'b1;
      #150;
      scl = 1'b1;
      #50;
      a = sdaIn;
      #50;
      scl = 1'b0;
      #150;
   endtask : getAck

   task automatic stop();
      sdaDrv = 1'b0;
      #50;
      scl = 1'b1;
      #50;
      sdaDrv = 1'b1;
      #100;
   endtask : stop
endmodule : remote_master

// >>> tb.sv
`timescale 1ns/1ps

`include "i2c_enable_spike_regs.svh"

module tb;
   localparam logic [7:0] addrWr = 8'hb4;
   localparam logic [7:0] otherWr = 8'h22;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic controllerEnable = 1'b0;
   logic [6:0] ownSlaveAddress = 7'h5a;
   logic [31:0] addr = 32'h0000_0000;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rdPend = 1'b0;
   logic [31:0] rdata;
   logic irq;
   logic controllerActive;
   logic sdaOut;
   logic sdaOe;
   logic scl;
   logic sdaDrv;
   logic sdaWire;
   logic [1:0] acks;
   logic [31:0] rv;
   logic [7:0] spk;
   logic [31:0] expQ[$];
   int fail_count = 0;
   int n_tests = 0;
   int seed = 32'ha6fa;

   always #12.5 clk = ~clk;
   // Open drain: either party pulls low
   assign sdaWire = sdaDrv & ~(sdaOe & ~sdaOut);

   i2c_enable_spike_top i2c_enable_spike_top_i (.clk(clk), .nrst(nrst),
      .controllerEnable(controllerEnable), .ownSlaveAddress(ownSlaveAddress),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
      .controllerActive(controllerActive), .sclIn(scl), .sdaIn(sdaWire),
      .sdaOut(sdaOut), .sdaOe(sdaOe));
   remote_master remote_master_i (.scl(scl), .sdaDrv(sdaDrv), .sdaIn(sdaWire));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkWord

   task automatic chkBit(input logic got, input logic exp);
      #1;
      chkWord({31'h0, got}, {31'h0, exp});
   endtask : chkBit

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   // Read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (rdPend) begin
         if (expQ.size() == 0) chkWord(rdata, 32'hdead_beef);
         else chkWord(rdata, expQ.pop_front());
      end
      rdPend <= rd;
   end

   task automatic regWrite(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : regWrite

   task automatic regRead(input logic [31:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      expQ.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask : regRead

   task automatic setEn(input logic v);
      @(posedge clk);
      controllerEnable <= v;
      repeat (2) @(posedge clk);
      #7;
   endtask : setEn

   // Address byte and one data byte; enable drops before bit cut, early stops there
   task automatic xfer(input logic [15:0] ad, input int cut, input logic early);
      acks = 2'bxx;
      remote_master_i.start();
      for (int i = 0; i < 16; i++) begin
         if (i == cut) setEn(1'b0);
         if (i == cut && early) break;
         remote_master_i.bitOut(ad[15 - i]);
         if (i == 7 || i == 15) remote_master_i.getAck(acks[i / 8]);
      end
      remote_master_i.stop();
   endtask : xfer

   task automatic endCase(input logic [31:0] readExp, input logic [2:0] stExp);
      int i;
      i = 0;
      while (controllerActive !== 1'b0 && i < 400) begin
         @(posedge clk);
         i++;
      end
      chkBit(controllerActive, 1'b0);
      regRead(`ENABLE_STATE_READBACK_OFS, readExp);
      chkBit(irq, |stExp[2:1]);
      regRead(`IRQ_STATUS_OFS, {29'h0, stExp});
      regWrite(`IRQ_STATUS_OFS, 32'h0000_0007);
      regRead(`IRQ_STATUS_OFS, 32'h0000_0000);
      chkBit(irq, 1'b0);
   endtask : endCase

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #500000;
      fail_count++;
      finish_test();
   end

   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      regRead(`ENABLE_STATE_READBACK_OFS, 32'h0000_0000);
      regRead(`GLITCH_FILTER_WIDTH_OFS, 32'h0000_0001);
      regRead(`IRQ_STATUS_OFS, 32'h0000_0000);
      regRead(`IRQ_MASK_OFS, 32'h0000_0000);
      regWrite(32'h5000_13b0, 32'hffff_ffff);
      regRead(32'h5000_13b0, 32'h0000_0000);
      $display("test reset values done");
      rv = $random(seed);
      spk = rv[7:0] | 8'h02;
      regWrite(`GLITCH_FILTER_WIDTH_OFS, {rv[31:8], spk});
      regRead(`GLITCH_FILTER_WIDTH_OFS, {24'h00_0000, spk});
      setEn(1'b1);
      chkBit(controllerActive, 1'b1);
      regRead(`ENABLE_STATE_READBACK_OFS, 32'h0000_0001);
      regWrite(`GLITCH_FILTER_WIDTH_OFS, 32'h0000_0003);
      regRead(`GLITCH_FILTER_WIDTH_OFS, {24'h00_0000, spk});
      setEn(1'b0);
      endCase(32'h0000_0000, 3'h1);
      regWrite(`GLITCH_FILTER_WIDTH_OFS, 32'h0000_0000);
      regRead(`GLITCH_FILTER_WIDTH_OFS, 32'h0000_0001);
      regWrite(`GLITCH_FILTER_WIDTH_OFS, 32'h0000_0001);
      regWrite(`IRQ_MASK_OFS, 32'h0000_0006);
      regRead(`IRQ_MASK_OFS, 32'h0000_0006);
      $display("test registers done");
      setEn(1'b1);
      remote_master_i.spkNs = 20;
      xfer({addrWr, rv[15:8]}, 99, 1'b0);
      remote_master_i.spkNs = 0;
      chkBit(acks[0], 1'b0);
      chkBit(acks[1], 1'b0);
      $display("test spike filter done");
      xfer({otherWr, rv[23:16]}, 3, 1'b0);
      chkBit(acks[0], 1'b1);
      endCase(32'h0000_0002, 3'h3);
      $display("test address abort done");
      setEn(1'b1);
      xfer({addrWr, rv[7:0]}, 11, 1'b0);
      chkBit(acks[0], 1'b0);
      chkBit(acks[1], 1'b1);
      endCase(32'h0000_0006, 3'h7);
      $display("test data abort done");
      setEn(1'b1);
      xfer({addrWr, rv[15:8]}, 11, 1'b1);
      endCase(32'h0000_0006, 3'h7);
      $display("test early stop done");
      setEn(1'b1);
      xfer({otherWr, rv[7:0]}, 11, 1'b0);
      chkBit(acks[0], 1'b1);
      endCase(32'h0000_0000, 3'h1);
      $display("test other traffic done");
      repeat (4) @(posedge clk);
      finish_test();
   end
endmodule : tb
